// ===== core/sync_counter_defines.svh
// constants for the presettable binary counter
`ifndef SYNC_COUNTER_DEFINES_SVH
`define SYNC_COUNTER_DEFINES_SVH

// counter width in bits
`define CNT_WIDTH 4
// terminal count that raises the carry
`define CNT_MAX 4'hf
// value forced by the synchronous clear
`define CNT_ZERO 4'h0
// value held under the asynchronous reset
`define CNT_RESET 4'h0
// increment applied per counting edge
`define CNT_STEP 4'h1

`endif

// ===== core/sync_counter_pkg.sv
// types shared by the counter and its bit cells
package sync_counter_pkg;
  `include "sync_counter_defines.svh"

  // count value
  typedef logic [`CNT_WIDTH-1:0] count_t;

  // control levels sampled at each rising edge
  typedef struct packed {
    logic syncClearN;
    logic loadN;
    logic parallelCountEnable;
    logic trickleCountEnable;
  } ctrl_t;

  // operation chosen for one edge, one-hot
  typedef enum logic [3:0] {
    MODE_CLEAR = 4'b0001,
    MODE_LOAD  = 4'b0010,
    MODE_COUNT = 4'b0100,
    MODE_HOLD  = 4'b1000
  } mode_t;
endpackage

// ===== core/count_bit_cell.sv
// one loadable toggle flip-flop of the counter
`timescale 1ns/1ps
module count_bit_cell
  import sync_counter_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clearBit,
  input  wire logic loadBit,
  input  wire logic presetBit,
  input  wire logic toggleBit,
  output logic      bitOut
);
  logic bit_r;
  logic bit_nxt;

  // clear beats load, load beats toggle
  assign bit_nxt = clearBit ? 1'b0 :
                   loadBit  ? presetBit :
                   (bit_r ^ toggleBit);

  // state changes on the rising clock edge, or at once when rst_b falls
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bit_r <= 1'b0;
    else
      bit_r <= bit_nxt;
  end

  assign bitOut = bit_r;
endmodule

// ===== core/sync_presettable_binary_counter.sv
// 4-bit synchronous presettable binary counter with cascade carry
`timescale 1ns/1ps
`include "sync_counter_defines.svh"
module sync_presettable_binary_counter
  import sync_counter_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   syncClearN,
  input  wire logic   loadN,
  input  wire logic   parallelCountEnable,
  input  wire logic   trickleCountEnable,
  input  wire count_t presetData,
  output count_t      countOut,
  output logic        carryOut
);

  // picks the operation for one edge from the sampled levels
  function automatic mode_t opOf(input ctrl_t c);
    mode_t m;
    m = MODE_HOLD;
    case (1'b1)
      !c.syncClearN:
        m = MODE_CLEAR;
      !c.loadN:
        m = MODE_LOAD;
      (c.parallelCountEnable && c.trickleCountEnable):
        m = MODE_COUNT;
      default:
        m = MODE_HOLD;
    endcase
    return m;
  endfunction

  ctrl_t  ctrl;
  mode_t  opMode;
  count_t count;
  logic   [`CNT_WIDTH-1:0] toggleVec;
  logic   atMax;
  logic   clearOp;
  logic   loadOp;
  logic   countOp;

  // bundle of the control inputs
  assign ctrl = '{syncClearN:          syncClearN,
                  loadN:               loadN,
                  parallelCountEnable: parallelCountEnable,
                  trickleCountEnable:  trickleCountEnable};

  // operation decode, clear first then load then count
  assign opMode  = opOf(ctrl);
  assign clearOp = (opMode == MODE_CLEAR);
  assign loadOp  = (opMode == MODE_LOAD);
  assign countOp = (opMode == MODE_COUNT);

  // look-ahead toggles: a bit flips when all lower bits are one
  genvar i;
  generate
    for (i = 0; i < `CNT_WIDTH; i++)
    begin : gBit
      if (i == 0)
      begin : gLsb
        assign toggleVec[i] = countOp;
      end
      else
      begin : gUpper
        assign toggleVec[i] = countOp & (&count[i-1:0]);
      end

      // each bit is its own flip-flop on the common clock
      count_bit_cell uCell (
        .clk       (clk),
        .rst_b     (rst_b),
        .clearBit  (clearOp),
        .loadBit   (loadOp),
        .presetBit (presetData[i]),
        .toggleBit (toggleVec[i]),
        .bitOut    (count[i])
      );
    end
  endgenerate

  // count leaves straight from the bit flip-flops
  assign countOut = count;

  // carry gated by the trickle enable only, not the parallel one
  assign atMax    = (count == `CNT_MAX);
  assign carryOut = trickleCountEnable & atMax;

  // checks on the counting behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_clear_forces_zero: assert property (
    !syncClearN |=> countOut == `CNT_ZERO
  ) else $error("clear did not zero the count");

  a_clear_over_load: assert property (
    (!syncClearN && !loadN && presetData != `CNT_ZERO)
      |=> countOut == `CNT_ZERO
  ) else $error("load won over clear");

  a_load_copies_data: assert property (
    (syncClearN && !loadN) |=> countOut == $past(presetData)
  ) else $error("load did not copy preset data");

  a_load_ignores_en: assert property (
    (syncClearN && !loadN && parallelCountEnable && trickleCountEnable)
      |=> countOut == $past(presetData)
  ) else $error("enables disturbed the load");

  a_count_steps_one: assert property (
    (syncClearN && loadN && parallelCountEnable && trickleCountEnable)
      |=> countOut == count_t'($past(countOut) + `CNT_STEP)
  ) else $error("count did not advance by one");

  a_hold_when_off: assert property (
    (syncClearN && loadN &&
     !(parallelCountEnable && trickleCountEnable))
      |=> $stable(countOut)
  ) else $error("count moved while disabled");

  a_change_has_cause: assert property (
    !$stable(countOut) |-> $past(opMode) != MODE_HOLD
  ) else $error("count changed without an operation");

  a_carry_exact: assert property (
    carryOut == (trickleCountEnable && countOut == `CNT_MAX)
  ) else $error("carry does not match enable and count");

  a_carry_no_enp: assert property (
    (trickleCountEnable && !parallelCountEnable && syncClearN && loadN &&
     countOut == `CNT_MAX) |-> carryOut ##1 carryOut || !trickleCountEnable
  ) else $error("carry depends on parallel enable");

  a_wrap_at_max: assert property (
    (countOut == `CNT_MAX && syncClearN && loadN &&
     parallelCountEnable && trickleCountEnable)
      |=> countOut == `CNT_ZERO ##1
          (countOut == `CNT_STEP || $past(opMode) != MODE_COUNT)
  ) else $error("count did not wrap from maximum to zero");

  a_cascade_carry: assert property (
    (carryOut && parallelCountEnable && syncClearN && loadN)
      |=> countOut == `CNT_ZERO
  ) else $error("stage did not roll over under carry");

  // carry stays low away from the terminal count
  a_carry_low_offmax: assert property (
    countOut != `CNT_MAX |-> !carryOut
  ) else $error("carry high below maximum");

  // carry is gated off by the trickle enable
  a_carry_low_no_t: assert property (
    !trickleCountEnable |-> !carryOut
  ) else $error("carry high without trickle enable");

  // carry lasts one cycle while counting through maximum
  a_carry_one_cycle: assert property (
    (carryOut && parallelCountEnable && syncClearN && loadN) |=> !carryOut
  ) else $error("carry did not drop after rollover");

  // clear acts with both enables high
  a_clear_ignores_en: assert property (
    (!syncClearN && parallelCountEnable && trickleCountEnable)
      |=> countOut == `CNT_ZERO
  ) else $error("enables disturbed the clear");

  // load acts with both enables low
  a_load_when_off: assert property (
    (syncClearN && !loadN && !parallelCountEnable && !trickleCountEnable)
      |=> countOut == $past(presetData)
  ) else $error("load needed the enables");

  // parallel enable low holds the count
  a_hold_p_low: assert property (
    (syncClearN && loadN && !parallelCountEnable) |=> $stable(countOut)
  ) else $error("count moved with parallel enable low");

  // trickle enable low holds the count
  a_hold_t_low: assert property (
    (syncClearN && loadN && !trickleCountEnable) |=> $stable(countOut)
  ) else $error("count moved with trickle enable low");

  // exactly one operation is chosen per edge
  a_mode_onehot: assert property (
    $onehot(opMode)
  ) else $error("operation decode not one-hot");

  // clear low always selects the clear operation
  a_clear_mode: assert property (
    !syncClearN |-> opMode == MODE_CLEAR
  ) else $error("clear not selected while clear low");

  // below maximum each counting edge moves upward
  a_count_upward: assert property (
    (countOp && countOut != `CNT_MAX) |=> countOut > $past(countOut)
  ) else $error("count did not move upward");

  // a cleared count stays zero while idle
  a_clear_then_hold: assert property (
    !syncClearN ##1
    (syncClearN && loadN && !(parallelCountEnable && trickleCountEnable))
      |=> countOut == `CNT_ZERO
  ) else $error("cleared count drifted");

  // counting resumes from the loaded value
  a_load_then_count: assert property (
    (syncClearN && !loadN) ##1
    (syncClearN && loadN && parallelCountEnable && trickleCountEnable)
      |=> countOut == count_t'($past(presetData, 2) + `CNT_STEP)
  ) else $error("count did not resume from preset");

endmodule

// ===== verif/count_limit_decoder.sv
// external decoder that shortens the count length
`timescale 1ns/1ps
module count_limit_decoder
  import sync_counter_pkg::*;
(
  input  wire logic   enable,
  input  wire count_t limit,
  input  wire count_t countIn,
  output logic        clearN
);
  // drive clear low once the chosen limit is reached
  assign clearN = !(enable && countIn == limit);
endmodule

// ===== verif/sync_presettable_binary_counter_tb.sv
// bench for the presettable binary counter
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module sync_presettable_binary_counter_tb
  import sync_counter_pkg::*;
;
  logic   clk = 0;
  logic   rst_b = 0;
  ctrl_t  c = '{1, 1, 0, 0};
  count_t pre = 4'h0;
  logic   decEn = 0;
  count_t countOut;
  logic   carryOut;
  logic   decClearN;
  int     fails = 0;
  int     samples_checked = 0;
  // clock generator
  always #10 clk = ~clk;
  count_limit_decoder u_dec (.enable(decEn), .limit(4'h5),
    .countIn(countOut), .clearN(decClearN));
  sync_presettable_binary_counter u_dut (.clk(clk), .rst_b(rst_b),
    .syncClearN(c.syncClearN & decClearN), .loadN(c.loadN),
    .parallelCountEnable(c.parallelCountEnable),
    .trickleCountEnable(c.trickleCountEnable), .presetData(pre),
    .countOut(countOut), .carryOut(carryOut));
  // one edge with given controls, then compare the count
  task op(input ctrl_t v, input count_t d, input count_t e);
    @(posedge clk);
    c <= v;
    pre <= d;
    @(posedge clk);
    // park on hold so the controls act on one edge only
    c <= '{1, 1, 0, v.trickleCountEnable};
    #1 `CHK(countOut, e)
  endtask
  task t_clear_load();
    op('{0, 1, 1, 1}, 4'h0, 4'h0);
    op('{1, 0, 1, 1}, 4'hc, 4'hc);
  endtask
  task t_count_wrap();
    for (int i = 13; i < 19; i++)
    begin
      op('{1, 1, 1, 1}, 4'h0, count_t'(i));
      if (i == 15)
        `CHK(carryOut, 1'b1)
    end
  endtask
  task t_hold_carry();
    op('{1, 1, 0, 1}, 4'h0, 4'h2);
    op('{1, 0, 0, 1}, 4'hf, 4'hf);
    `CHK(carryOut, 1'b1)
    op('{1, 1, 1, 0}, 4'h0, 4'hf);
    `CHK(carryOut, 1'b0)
  endtask
  task t_priority();
    op('{0, 0, 1, 1}, 4'h9, 4'h0);
  endtask
  task t_shorten();
    decEn <= 1;
    op('{1, 0, 0, 0}, 4'h4, 4'h4);
    op('{1, 1, 1, 1}, 4'h0, 4'h5);
    op('{1, 1, 0, 0}, 4'h0, 4'h0);
    decEn <= 0;
  endtask
  task test_done();
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #(2000 * 20);
    fails++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    t_clear_load();
    t_count_wrap();
    t_hold_carry();
    t_priority();
    t_shorten();
    test_done();
  end
endmodule
